/* include/capture_pkg.sv */
package capture_pkg;

	// ---------------------------------------------------------------
	// buffer geometry
	// ---------------------------------------------------------------
	localparam int          DEPTH       = 8192;
	localparam int          IDX_W       = 13;
	localparam int          CNT_W       = 14;
	localparam logic [13:0] CNT_FULL    = 14'h2000;
	localparam int          N_RANGES    = 8;

	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_VEC_LIST = 8'h08;
	localparam logic [7:0] OFS_RANGE_EN = 8'h0C;
	localparam logic [7:0] OFS_RD_PTR   = 8'h10;
	localparam logic [7:0] OFS_ENTRY    = 8'h14;
	localparam logic [2:0] RANGE_PAGE   = 3'h1;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_EXCL_BIT  = 3;
	localparam int CTRL_ARM_BIT   = 4;
	localparam int CTRL_DISARM_BIT = 5;
	localparam int ST_ARMED_BIT   = 0;
	localparam int ST_ACTIVE_BIT  = 1;
	localparam int ST_FULL_BIT    = 2;
	localparam int ST_EMPTY_BIT   = 3;
	localparam int ST_REFUSED_BIT = 4;
	localparam int ST_NMI_BIT     = 5;
	localparam int ST_COUNT_LSB   = 16;

	// ---------------------------------------------------------------
	// qualifier modes
	// ---------------------------------------------------------------
	localparam logic [2:0] MODE_READ   = 3'h0;
	localparam logic [2:0] MODE_WRITE  = 3'h1;
	localparam logic [2:0] MODE_ACCESS = 3'h2;
	localparam logic [2:0] MODE_EEPROM = 3'h3;
	localparam logic [2:0] MODE_VECTOR = 3'h4;

	// ---------------------------------------------------------------
	// address windows and reserved vectors
	// ---------------------------------------------------------------
	localparam logic [15:0] LOW_LO       = 16'h0000;
	localparam logic [15:0] LOW_HI       = 16'h1FFF;
	localparam logic [15:0] EE_LO        = 16'hB600;
	localparam logic [15:0] EE_HI        = 16'hB7FF;
	localparam logic [15:0] VEC_LO       = 16'hFFC0;
	localparam logic [15:0] VEC_HI       = 16'hFFFE;
	localparam logic [15:0] PSEUDO_NMI_VECTOR    = 16'hFFF4;
	localparam logic [15:0] SOFT_INTERRUPT_VECTOR = 16'hFFF6;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [31:0] RST_VEC_LIST = 32'h0000_0000;
	localparam logic [7:0]  RST_RANGE_EN = 8'h00;
	localparam logic [15:0] RST_ADDR     = 16'h0000;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_ARMED   = 2'b01,
		ST_CAPTURE = 2'b11,
		ST_DONE    = 2'b10
	} cap_state_e;

	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
	                                  input logic [15:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] wd,
	                                          input logic [3:0] sel);
		merge_sel = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				merge_sel[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
	endfunction

endpackage

/* include/capture_store_if.sv */
`timescale 1ns/1ps
interface capture_store_if;
	logic        wr_en;
	logic [12:0] wr_idx;
	logic [31:0] wr_word;
	logic [12:0] rd_idx;
	logic [31:0] rd_word;

	modport ctrl (output wr_en, output wr_idx, output wr_word, output rd_idx, input rd_word);
	modport store (input wr_en, input wr_idx, input wr_word, input rd_idx, output rd_word);
endinterface

/* verilog/capture_store.sv */
`timescale 1ns/1ps
module capture_store (
	// clock and reset
	input  wire logic     ref_clk,
	input  wire logic     reset,
	// entry port
	capture_store_if.store port
);

	typedef struct packed {
		logic [31:0] rd_word;
	} store_s;

	store_s      r_reg;
	store_s      r_next;
	// kept apart from the struct: a packed 8192-word vector is too wide for many tools
	logic [31:0] mem [capture_pkg::DEPTH];

	always_comb begin
		r_next = r_reg;
		// read lags the index by one cycle
		r_next.rd_word = mem[port.rd_idx];
	end

	// contents are not cleared; the entry count decides what is valid
	always_ff @(posedge ref_clk) begin
		if (port.wr_en) begin
			mem[port.wr_idx] <= port.wr_word;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign port.rd_word = r_reg.rd_word;

endmodule // capture_store

/* verilog/bus_cycle_selective_capture.sv */
// Behaviour
// R01: read mode stores only reads hitting an armed address inside the low range.
// R02: write mode stores only writes hitting an armed address inside the low range.
// R03: access mode stores reads and writes hitting an armed low-range address.
// R04: eeprom mode stores writes hitting armed addresses inside the eeprom window.
// R05: vector mode, empty list: all vectors except the two monitor vectors.
// R06: vector mode, exclusion list: all vectors except those listed; the code also leaves out the two monitor vectors.
// R07: vector mode, plain list: only the listed vectors.
// R08: software gives upper bound above lower bound and even vector addresses.
// R09: software picks one mode per arming with at least one address.
// R10: up to 8192 entries; full buffer raises the nmi.
// R11: completed capture leaves the read pointer at the first entry.
// R12: early stop keeps entries readable; no trigger means empty buffer.
// R13: arming acts on next user run; new arming cancels the old one.
// R14: monitor neither plants breakpoints nor single-steps while armed.
// R15: vector mode stores fetched vector addresses in order, no timing.
// R16: eeprom mode is refused unless the eeprom is present.
// R17: entry holds address, data and aux byte of probes, marker, rw.
// R18: aux byte is probes in bits 7..2, rw bit 1, marker bit 0.
// R19: marker set only on the first cycle of an instruction.
// R20: vector match needs a read at an even address in the enabled set.
// R21: reset empties the buffer and disarms the capture.
`timescale 1ns/1ps
module bus_cycle_selective_capture (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// monitored bus
	input  wire logic        bus_cycle_valid,
	input  wire logic [15:0] bus_addr,
	input  wire logic [7:0]  bus_data,
	input  wire logic        bus_rw,
	input  wire logic        first_cycle_flag,
	input  wire logic [5:0]  user_probe_inputs,
	// run control
	input  wire logic        user_run,
	input  wire logic        eeprom_present,
	// interrupt
	output logic             nmi
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		// capture control
		capture_pkg::cap_state_e                state;
		logic [2:0]                             mode;
		logic                                   excl;
		logic                                   refused;
		// trigger set
		logic [31:0]                            vec_list;
		logic [7:0]                             range_en;
		logic [capture_pkg::N_RANGES-1:0][15:0] lo;
		logic [capture_pkg::N_RANGES-1:0][15:0] hi;
		// buffer bookkeeping
		logic [13:0]                            count;
		logic [12:0]                            rd_ptr;
		logic                                   full;
		logic                                   nmi;
		// run edge finder and bus answer
		logic                                   run_d;
		logic                                   ack;
		logic [31:0]                            dat;
	} cap_s;

	cap_s r_reg;
	cap_s r_next;

	capture_store_if store_port ();

	capture_store u_store (
		.ref_clk (ref_clk),
		.reset   (reset),
		.port    (store_port.store)
	);

	// qualifier terms
	logic        list_hit;
	logic        low_ok;
	logic        ee_ok;
	logic        vec_ok;
	logic [4:0]  vec_idx;
	logic        vec_reserved;
	logic        vec_on;
	logic        qualified;
	logic        store_now;

	// register bus views
	logic        bus_req;
	logic [2:0]  rng_idx;
	logic [31:0] rng_word;
	logic [31:0] status_word;
	logic [31:0] ctrl_new;
	logic [2:0]  arm_mode;
	logic        arm_valid;

	// ---------------------------------------------------------------
	// qualifier
	// ---------------------------------------------------------------
	always_comb begin
		// a slot whose low bound sits above its high bound never matches
		list_hit = 1'b0;
		for (int i = 0; i < capture_pkg::N_RANGES; i++) begin
			if (r_reg.range_en[i] &&
			    capture_pkg::in_range(bus_addr, r_reg.lo[i], r_reg.hi[i])) begin
				list_hit = 1'b1;
			end
		end

		low_ok  = capture_pkg::in_range(bus_addr, capture_pkg::LOW_LO, capture_pkg::LOW_HI);
		ee_ok   = capture_pkg::in_range(bus_addr, capture_pkg::EE_LO, capture_pkg::EE_HI);
		// odd addresses are the low byte of a vector and never match
		vec_ok  = capture_pkg::in_range(bus_addr, capture_pkg::VEC_LO, capture_pkg::VEC_HI)
		          && !bus_addr[0]; // R20
		vec_idx = bus_addr[5:1];

		// the two monitor vectors stay out of the implicit set
		vec_reserved = (bus_addr == capture_pkg::PSEUDO_NMI_VECTOR) ||
		               (bus_addr == capture_pkg::SOFT_INTERRUPT_VECTOR);
		if (r_reg.vec_list == capture_pkg::RST_VEC_LIST) begin
			vec_on = !vec_reserved; // R05
		end else if (r_reg.excl) begin
			vec_on = !vec_reserved && !r_reg.vec_list[vec_idx]; // R06
		end else begin
			vec_on = r_reg.vec_list[vec_idx]; // R07
		end

		unique case (r_reg.mode)
			capture_pkg::MODE_READ: begin
				qualified = bus_rw && low_ok && list_hit; // R01
			end
			capture_pkg::MODE_WRITE: begin
				qualified = !bus_rw && low_ok && list_hit; // R02
			end
			capture_pkg::MODE_ACCESS: begin
				qualified = low_ok && list_hit; // R03
			end
			capture_pkg::MODE_EEPROM: begin
				qualified = !bus_rw && ee_ok && list_hit; // R04
			end
			capture_pkg::MODE_VECTOR: begin
				qualified = bus_rw && vec_ok && vec_on; // R20
			end
			// a refused arming can leave an unused mode code behind
			default: begin
				qualified = 1'b0;
			end
		endcase

		// a full buffer ignores further cycles until the next arming
		store_now = (r_reg.state == capture_pkg::ST_CAPTURE) && bus_cycle_valid &&
		            qualified && !r_reg.full;
	end

	// ---------------------------------------------------------------
	// store port
	// ---------------------------------------------------------------
	assign store_port.wr_en   = store_now;
	assign store_port.wr_idx  = r_reg.count[12:0];
	// vector mode keeps the same layout; the address field is the vector
	assign store_port.wr_word = {user_probe_inputs, bus_rw, first_cycle_flag,
	                             bus_data, bus_addr}; // R17 R18 R19 R15
	assign store_port.rd_idx  = r_reg.rd_ptr;

	// ---------------------------------------------------------------
	// register views
	// ---------------------------------------------------------------
	always_comb begin
		bus_req  = wb_cyc_i && wb_stb_i && !r_reg.ack;
		rng_idx  = wb_adr_i[4:2];
		rng_word = {r_reg.hi[rng_idx], r_reg.lo[rng_idx]};

		status_word = 32'h0000_0000;
		status_word[capture_pkg::ST_ARMED_BIT]   = (r_reg.state == capture_pkg::ST_ARMED) ||
		                                           (r_reg.state == capture_pkg::ST_CAPTURE);
		status_word[capture_pkg::ST_ACTIVE_BIT]  = (r_reg.state == capture_pkg::ST_CAPTURE);
		status_word[capture_pkg::ST_FULL_BIT]    = r_reg.full;
		status_word[capture_pkg::ST_EMPTY_BIT]   = (r_reg.count == 14'h0000); // R12
		status_word[capture_pkg::ST_REFUSED_BIT] = r_reg.refused;
		status_word[capture_pkg::ST_NMI_BIT]     = r_reg.nmi;
		status_word[capture_pkg::ST_COUNT_LSB +: 14] = r_reg.count;

		// arming looks only at the lanes written; the others read as zero
		ctrl_new  = capture_pkg::merge_sel(32'h0000_0000, wb_dat_i, wb_sel_i);
		arm_mode  = ctrl_new[capture_pkg::CTRL_MODE_LSB +: 3];
		arm_valid = (arm_mode <= capture_pkg::MODE_VECTOR) &&
		            !((arm_mode == capture_pkg::MODE_EEPROM) && !eeprom_present); // R16
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		r_next       = r_reg;
		r_next.ack   = 1'b0;
		// start of a user run; a run already going never starts a capture
		r_next.run_d = user_run;

		unique case (r_reg.state)
			capture_pkg::ST_IDLE: begin
			end

			capture_pkg::ST_ARMED: begin
				if (user_run && !r_reg.run_d) begin
					r_next.state = capture_pkg::ST_CAPTURE; // R13
				end
			end

			capture_pkg::ST_CAPTURE: begin
				if (store_now) begin
					r_next.count = r_reg.count + 14'h0001;
				end

				// last free slot fills on this edge: stop, interrupt, rewind
				if (store_now && (r_reg.count + 14'h0001 == capture_pkg::CNT_FULL)) begin
					r_next.full   = 1'b1;
					r_next.nmi    = 1'b1; // R10
					r_next.state  = capture_pkg::ST_DONE;
					r_next.rd_ptr = 13'h0000; // R11
				end else if (!user_run) begin
					// stopped early: whatever was stored stays readable
					r_next.state  = capture_pkg::ST_DONE; // R12
					r_next.rd_ptr = 13'h0000; // R11
				end
			end

			capture_pkg::ST_DONE: begin
				// the monitor has control back once the user program stops
				if (!user_run) begin
					r_next.nmi = 1'b0;
				end
			end
		endcase

		if (bus_req) begin
			r_next.ack = 1'b1;
			r_next.dat = 32'h0000_0000;
			// one page of eight range slots, high bound in the upper half-word
			if (wb_adr_i[7:5] == capture_pkg::RANGE_PAGE) begin
				if (wb_we_i) begin
					{r_next.hi[rng_idx], r_next.lo[rng_idx]} =
						capture_pkg::merge_sel(rng_word, wb_dat_i, wb_sel_i);
				end else begin
					r_next.dat = rng_word;
				end
			end else begin
				unique case (wb_adr_i)
					capture_pkg::OFS_CTRL: begin
						if (wb_we_i && ctrl_new[capture_pkg::CTRL_ARM_BIT]) begin
							// arming wipes the buffer and the earlier mode set-up; ranges and vector list are kept
							r_next.count   = 14'h0000; // R13
							r_next.full    = 1'b0;
							r_next.nmi     = 1'b0;
							r_next.rd_ptr  = 13'h0000;
							// a refused arming still cancels the old set-up
							r_next.refused = !arm_valid;
							r_next.mode    = arm_mode;
							r_next.excl    = ctrl_new[capture_pkg::CTRL_EXCL_BIT];
							r_next.state   = arm_valid ? capture_pkg::ST_ARMED :
							                             capture_pkg::ST_IDLE; // R16
						end else if (wb_we_i && ctrl_new[capture_pkg::CTRL_DISARM_BIT]) begin
							// stored entries stay readable after a disarm
							r_next.state = capture_pkg::ST_IDLE;
							r_next.nmi   = 1'b0;
						end else if (!wb_we_i) begin
							r_next.dat[capture_pkg::CTRL_MODE_LSB +: 3] = r_reg.mode;
							r_next.dat[capture_pkg::CTRL_EXCL_BIT]      = r_reg.excl;
						end
					end

					capture_pkg::OFS_STATUS: begin
						if (!wb_we_i) begin
							r_next.dat = status_word;
						end
					end

					capture_pkg::OFS_VEC_LIST: begin
						if (wb_we_i) begin
							r_next.vec_list = capture_pkg::merge_sel(r_reg.vec_list,
							                                         wb_dat_i, wb_sel_i);
						end else begin
							r_next.dat = r_reg.vec_list;
						end
					end

					capture_pkg::OFS_RANGE_EN: begin
						if (wb_we_i && wb_sel_i[0]) begin
							r_next.range_en = wb_dat_i[7:0];
						end else if (!wb_we_i) begin
							r_next.dat[7:0] = r_reg.range_en;
						end
					end

					capture_pkg::OFS_RD_PTR: begin
						if (wb_we_i && (wb_sel_i[1:0] == 2'b11)) begin
							r_next.rd_ptr = wb_dat_i[12:0];
						end else if (!wb_we_i) begin
							r_next.dat[12:0] = r_reg.rd_ptr;
						end
					end

					capture_pkg::OFS_ENTRY: begin
						// reading an entry steps the pointer on to the next one
						if (!wb_we_i) begin
							r_next.dat    = store_port.rd_word;
							r_next.rd_ptr = r_reg.rd_ptr + 13'h0001;
						end
					end

					default: begin
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			// constants only; the entry store itself is never cleared
			r_reg          <= '0; // R21
			r_reg.state    <= capture_pkg::ST_IDLE;
			r_reg.mode     <= capture_pkg::MODE_READ;
			r_reg.vec_list <= capture_pkg::RST_VEC_LIST;
			r_reg.range_en <= capture_pkg::RST_RANGE_EN;
		end else begin
			r_reg <= r_next;
		end
	end

	assign wb_ack_o = r_reg.ack;
	assign wb_dat_o = r_reg.dat;
	assign nmi      = r_reg.nmi;

endmodule // bus_cycle_selective_capture

/* tb/capture_checker_properties.sv */
`timescale 1ns/1ps
module capture_checker (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        reset,
	// register bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// monitored side
	input wire logic        bus_cycle_valid,
	input wire logic        user_run,
	input wire logic        nmi
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	property p_ack_follows; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_follows: assert property (p_ack_follows) else $error("ack late");
	property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
	property p_ack_single; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_single: assert property (p_ack_single) else $error("ack too long");
	property p_dat_hold; !wb_ack_o |-> $stable(wb_dat_o); endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
	property p_nmi_cause; $rose(nmi) |-> $past(bus_cycle_valid) && $past(user_run); endproperty
	a_nmi_cause: assert property (p_nmi_cause) else $error("nmi without store");
	property p_nmi_hold; nmi && user_run && !(wb_cyc_i && wb_we_i) |=> nmi; endproperty
	a_nmi_hold: assert property (p_nmi_hold) else $error("nmi dropped");
	property p_nmi_clear; nmi && !user_run |=> !nmi; endproperty
	a_nmi_clear: assert property (p_nmi_clear) else $error("nmi stuck");
	property p_reset_quiet; $fell(reset) |-> !nmi && !wb_ack_o && wb_dat_o == 32'h0; endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("not quiet after reset");
endmodule // capture_checker

bind bus_cycle_selective_capture capture_checker u_chk (.ref_clk(ref_clk), .reset(reset),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .bus_cycle_valid(bus_cycle_valid), .user_run(user_run), .nmi(nmi));

/* tb/mcu_bus_model.sv */
`timescale 1ns/1ps
module mcu_bus_model (
	// clock
	input wire logic    ref_clk,
	// monitored bus
	output logic        bus_cycle_valid,
	output logic [15:0] bus_addr,
	output logic [7:0]  bus_data,
	output logic        bus_rw,
	output logic        first_cycle_flag,
	output logic [5:0]  user_probe_inputs,
	output logic        user_run
);
	initial begin
		bus_cycle_valid = 1'b0;
		bus_addr = 16'hFFFF;
		bus_data = 8'h00;
		bus_rw = 1'b1;
		first_cycle_flag = 1'b0;
		user_probe_inputs = 6'h00;
		user_run = 1'b0;
	end
	// fields invert after the pulse so a stale value never looks valid
	task automatic cycle(input logic [15:0] a, input logic rw, input logic [7:0] d,
		input logic [5:0] p, input logic f);
		@(posedge ref_clk);
		bus_cycle_valid <= 1'b1;
		bus_addr <= a;
		bus_data <= d;
		bus_rw <= rw;
		first_cycle_flag <= f;
		user_probe_inputs <= p;
		@(posedge ref_clk);
		bus_cycle_valid <= 1'b0;
		bus_addr <= ~a;
		bus_data <= ~d;
		bus_rw <= ~rw;
		first_cycle_flag <= ~f;
		user_probe_inputs <= ~p;
	endtask
	task automatic run(input logic on);
		@(posedge ref_clk);
		user_run <= on;
	endtask
endmodule // mcu_bus_model

/* tb/bus_cycle_selective_capture_bench.sv */
`timescale 1ns/1ps
module bus_cycle_selective_capture_bench;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        bus_cycle_valid;
	logic [15:0] bus_addr;
	logic [7:0]  bus_data;
	logic        bus_rw;
	logic        first_cycle_flag;
	logic [5:0]  user_probe_inputs;
	logic        user_run;
	logic        eeprom_present = 1'b1;
	logic        nmi;
	logic [31:0] rd;
	logic [3:0]  lanes = 4'hF;
	int          failures = 0;
	int          check_count = 0;
	// bit 16 is the read level
	logic [16:0] cl [11] = '{17'h1_0010, 17'h0_0010, 17'h1_0011, 17'h0_B7F0, 17'h1_B7F0,
		17'h1_FFF0, 17'h1_FFF4, 17'h1_FFF6, 17'h1_FFF2, 17'h1_FFF1, 17'h0_FFF0};

	always #4 ref_clk = ~ref_clk;

	bus_cycle_selective_capture u_dut (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.bus_cycle_valid(bus_cycle_valid), .bus_addr(bus_addr), .bus_data(bus_data),
		.bus_rw(bus_rw), .first_cycle_flag(first_cycle_flag),
		.user_probe_inputs(user_probe_inputs), .user_run(user_run),
		.eeprom_present(eeprom_present), .nmi(nmi));
	mcu_bus_model u_mcu (.ref_clk(ref_clk), .bus_cycle_valid(bus_cycle_valid),
		.bus_addr(bus_addr), .bus_data(bus_data), .bus_rw(bus_rw),
		.first_cycle_flag(first_cycle_flag), .user_probe_inputs(user_probe_inputs),
		.user_run(user_run));

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= lanes;
		wb_dat_i <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) failures++;
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic arm(input logic [2:0] m, input logic x);
		wb(1'b1, capture_pkg::OFS_CTRL, {27'h0, 1'b1, x, m});
	endtask
	function automatic logic hit(input logic [2:0] m, input logic x, input logic [31:0] v,
		input logic [16:0] c);
		logic mon;
		mon = c[15:0] == capture_pkg::PSEUDO_NMI_VECTOR
			|| c[15:0] == capture_pkg::SOFT_INTERRUPT_VECTOR;
		case (m)
			capture_pkg::MODE_READ: hit = c[16] && c[15:0] == 16'h0010;
			capture_pkg::MODE_WRITE: hit = !c[16] && c[15:0] == 16'h0010;
			capture_pkg::MODE_ACCESS: hit = c[15:0] == 16'h0010;
			capture_pkg::MODE_EEPROM: hit = !c[16] && c[15:0] == 16'hB7F0;
			default: hit = c[16] && !c[0] && c[15:0] >= capture_pkg::VEC_LO
				&& (v == 0 ? !mon : x ? !(v[c[5:1]] || mon) : v[c[5:1]]);
		endcase
	endfunction

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic run_mode(input logic [2:0] m, input logic x, input logic [31:0] v);
		int n;
		n = 0;
		wb(1'b1, capture_pkg::OFS_VEC_LIST, v);
		arm(m, x);
		u_mcu.run(1'b1);
		foreach (cl[i]) u_mcu.cycle(cl[i][15:0], cl[i][16], 8'hA0 + 8'(i), 6'(i) ^ 6'h2A, i[0]);
		u_mcu.run(1'b0);
		repeat (2) @(posedge ref_clk);
		foreach (cl[i]) begin
			if (hit(m, x, v, cl[i])) begin
				wb(1'b0, capture_pkg::OFS_ENTRY, 32'h0);
				check(rd, {6'(i) ^ 6'h2A, cl[i][16], i[0], 8'hA0 + 8'(i), cl[i][15:0]});
				n++;
			end
		end
		wb(1'b0, capture_pkg::OFS_STATUS, 32'h0);
		check({18'h0, rd[29:16]}, 32'(n));
	endtask
	task automatic fill_buffer;
		arm(capture_pkg::MODE_ACCESS, 1'b0);
		u_mcu.run(1'b1);
		for (int k = 0; k < 8192; k++) u_mcu.cycle(16'h0010, k[0], 8'(k), 6'h00, 1'b0);
		repeat (2) @(posedge ref_clk);
		check({31'h0, nmi}, 32'h1);
		u_mcu.cycle(16'h0010, 1'b1, 8'h55, 6'h00, 1'b0);
		wb(1'b0, capture_pkg::OFS_STATUS, 32'h0);
		check(rd & 32'h3FFF_0024, 32'h2000_0024);
		u_mcu.run(1'b0);
		repeat (2) @(posedge ref_clk);
		check({31'h0, nmi}, 32'h0);
		wb(1'b0, capture_pkg::OFS_ENTRY, 32'h0);
		check(rd, 32'h0000_0010);
		wb(1'b1, capture_pkg::OFS_RD_PTR, 32'h0000_0003);
		wb(1'b0, capture_pkg::OFS_ENTRY, 32'h0);
		check(rd, 32'h0203_0010);
	endtask

	initial begin
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		wb(1'b0, capture_pkg::OFS_STATUS, 32'h0);
		check(rd, 32'h0000_0008);
		wb(1'b0, 8'h18, 32'h0);
		check(rd, 32'h0);
		// bounds kept ascending, one mode per arming
		wb(1'b1, 8'h20, 32'h0010_000F);
		wb(1'b1, 8'h24, 32'hB7F0_B7EF);
		wb(1'b1, capture_pkg::OFS_RANGE_EN, 32'h3);
		lanes = 4'hE;
		wb(1'b1, capture_pkg::OFS_RANGE_EN, 32'h0);
		lanes = 4'hF;
		wb(1'b0, capture_pkg::OFS_RANGE_EN, 32'h0);
		check(rd, 32'h3);
		eeprom_present <= 1'b0;
		arm(capture_pkg::MODE_EEPROM, 1'b0);
		wb(1'b0, capture_pkg::OFS_STATUS, 32'h0);
		check(rd & 32'h11, 32'h10);
		arm(3'h5, 1'b0);
		wb(1'b0, capture_pkg::OFS_STATUS, 32'h0);
		check(rd & 32'h11, 32'h10);
		eeprom_present <= 1'b1;
		u_mcu.run(1'b1);
		arm(capture_pkg::MODE_READ, 1'b0);
		u_mcu.cycle(16'h0010, 1'b1, 8'h01, 6'h00, 1'b1);
		u_mcu.run(1'b0);
		wb(1'b0, capture_pkg::OFS_STATUS, 32'h0);
		check(rd & 32'h3FFF_0008, 32'h8);
		check(rd & 32'h3, 32'h1);
		wb(1'b1, capture_pkg::OFS_CTRL, 32'h0000_0020);
		wb(1'b0, capture_pkg::OFS_STATUS, 32'h0);
		check(rd & 32'h3, 32'h0);
		for (int m = 0; m < 4; m++) run_mode(3'(m), 1'b0, 32'h0);
		run_mode(capture_pkg::MODE_VECTOR, 1'b0, 32'h0);
		run_mode(capture_pkg::MODE_VECTOR, 1'b1, 32'h0100_0000);
		run_mode(capture_pkg::MODE_VECTOR, 1'b0, 32'h0300_0000);
		fill_buffer();
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		wb(1'b0, capture_pkg::OFS_STATUS, 32'h0);
		check(rd, 32'h0000_0008);
		conclude();
	end

	initial begin
		repeat (40000) @(posedge ref_clk);
		failures++;
		conclude();
	end
endmodule // bus_cycle_selective_capture_bench
